// ---- src/ssp_pkg.sv ----
package ssp_pkg;
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h2a;
  localparam logic [7:0] FLAGS_OFS = 8'h28;
  localparam logic [7:0] DATA_OFS = 8'h29;
  // Control field positions
  localparam int RATE_LO = 0;
  localparam int PHA_BIT = 2;
  localparam int POL_BIT = 3;
  localparam int MASTER_SELECT_BIT = 4;
  localparam int BOS_BIT = 5;
  localparam int EN_BIT = 6;
  localparam int MODE_BIT = 7;
  // Flag positions in the flags register
  localparam int DONE_BIT = 7;
  localparam int WRITE_COLLISION_FLAG_BIT = 6;
  localparam int OVF_BIT = 5;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Half-period counts for the four rate codes (divide by 4/8/16/64)
  localparam logic [4:0] HALF_DIV4 = 5'h01;
  localparam logic [4:0] HALF_DIV8 = 5'h03;
  localparam logic [4:0] HALF_DIV16 = 5'h07;
  localparam logic [4:0] HALF_DIV64 = 5'h1f;
  localparam logic [3:0] EDGES_PER_BYTE = 4'h0;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  typedef enum logic [1:0] {
    SSP_IDLE = 2'b00,
    SSP_LEAD = 2'b01,
    SSP_RUN = 2'b10
  } ssp_state_t;
endpackage

// ---- src/ssp_sync.sv ----
`timescale 1ns/1ps
// Three-stage pin synchroniser; output changes once stages two and three agree
module ssp_sync
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin in, filtered level out
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // Agreement of last two stages
  assign next_level = (s2 == s3) ? s3 : level;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

// ---- src/ssp_shifter.sv ----
`timescale 1ns/1ps
// Eight-bit shift register; one register carries out and in data
module ssp_shifter
  import ssp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Parallel load
  input wire logic load,
  input wire logic [7:0] load_data,
  // Serial control
  input wire logic lsb_first,
  input wire logic sample,
  input wire logic shift,
  input wire logic serial_in,
  // Outputs
  output logic serial_out,
  output logic [7:0] data
);
  logic held_bit;
  logic [7:0] shifted;

  // Shift direction per bit order
  assign shifted = lsb_first ? {held_bit, data[7:1]} : {data[6:0], held_bit};
  assign serial_out = lsb_first ? data[0] : data[7];

  // Sample holds the bit; shift moves it in
  always_ff @(posedge clock) begin
    if (rst) begin
      data <= DATA_RST;
      held_bit <= 1'b0;
    end else if (load) begin
      data <= load_data;
    end else begin
      if (sample) begin
        held_bit <= serial_in;
      end
      if (shift) begin
        data <= shifted;
      end
    end
  end
endmodule

// ---- src/ssp_top.sv ----
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Clock pin output as master, input slave
// - Master gives eight pulses, idle otherwise
// - Eight bits move each way together
// - Master drives mosi; slave drives miso
// - Deselected slave ignores clock, miso off
// - Shift one edge, sample the other
// - Phase zero edge selection by polarity
// - Phase one edge selection by polarity
// - Phase zero master: bit leads clock
// - Phase one master: bit at first edge
// - Bit order selects msb or lsb first
// - Done flag set after last shift; phase one sets it one cycle before its final shift
// - Slave phase zero write, select low collides
// - Slave phase one writes allowed when idle
// - Write during transfer sets collision
// - Shift register ends holding received byte
// - Slave overflow when done still set
// - Four master rates from system clock
// - Phase bit two, polarity bit three
// - Flags clear on status read then data access
// - Interrupt on done rising edge
// - Rate code divides by 4,8,16,64
module ssp_top
  import ssp_pkg::*;
(
  // System clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial clock pin
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  // Master-out pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  // Master-in pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // Slave select, active low
  input wire logic ss_n,
  // Interrupt request
  output logic transfer_done_irq
);
  logic [7:0] ctrl;
  logic done_flag;
  logic write_collision_flag_flag;
  logic ovf_flag;
  logic status_seen;
  ssp_state_t state;
  ssp_state_t next_state;
  logic [4:0] div_cnt;
  logic [3:0] edge_cnt;
  logic sclk_int;
  logic sclk_lvl;
  logic sclk_prev;
  logic ss_lvl;
  logic done_prev;

  // Control fields
  logic pha;
  logic pol;
  logic master_select;
  logic lsb_first;
  logic enable;
  logic [1:0] rate;
  assign rate = ctrl[RATE_LO+1:RATE_LO];
  assign pha = ctrl[PHA_BIT];
  assign pol = ctrl[POL_BIT];
  assign master_select = ctrl[MASTER_SELECT_BIT];
  assign lsb_first = ctrl[BOS_BIT];
  assign enable = ctrl[EN_BIT];

  // Register decode
  logic wr_ctrl;
  logic wr_data;
  logic rd_flags;
  logic rd_data;
  logic data_access;
  assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
  assign wr_data = reg_wr && (reg_addr == DATA_OFS);
  assign rd_flags = reg_rd && (reg_addr == FLAGS_OFS);
  assign rd_data = reg_rd && (reg_addr == DATA_OFS);
  assign data_access = wr_data || rd_data;

  function automatic logic [4:0] half_of(input logic [1:0] code);
    unique case (code)
      2'b00: half_of = HALF_DIV4;
      2'b01: half_of = HALF_DIV8;
      2'b10: half_of = HALF_DIV16;
      2'b11: half_of = HALF_DIV64;
    endcase
  endfunction

  ssp_sync u_sync_sclk (
    .clock(clock),
    .rst(rst),
    .pin(sclk_in),
    .level(sclk_lvl)
  );
  ssp_sync u_sync_ss (
    .clock(clock),
    .rst(rst),
    .pin(ss_n),
    .level(ss_lvl)
  );

  // Master timing
  logic busy;
  logic half_tick;
  logic m_edge;
  logic m_leading;
  assign busy = (state != SSP_IDLE);
  assign half_tick = busy && (div_cnt == 5'h00);
  assign m_edge = (state == SSP_RUN) && half_tick;
  // Leading edge is the first of each pair, at an even edge count
  assign m_leading = (edge_cnt[0] == 1'b0);

  // Slave edge detection
  logic slave_sel;
  logic s_rise;
  logic s_fall;
  logic s_leading;
  logic s_edge;
  assign slave_sel = enable && !master_select && !ss_lvl;
  assign s_rise = slave_sel && sclk_lvl && !sclk_prev;
  assign s_fall = slave_sel && !sclk_lvl && sclk_prev;
  assign s_leading = pol ? s_fall : s_rise;
  assign s_edge = s_rise || s_fall;

  // leading edge samples at phase 0, shifts at phase 1
  logic any_edge;
  logic is_leading;
  logic do_sample;
  logic do_shift;
  assign any_edge = master_select ? m_edge : s_edge;
  assign is_leading = master_select ? m_leading : s_leading;
  assign do_sample = any_edge && (is_leading ^ pha);
  // phase one: last sampled bit moves in a cycle later
  logic tail_shift;
  assign do_shift = (any_edge && !(is_leading ^ pha) &&
                    !(pha && (edge_cnt == EDGES_PER_BYTE))) || tail_shift;

  // Slave and master transfer bookkeeping
  logic s_last;
  logic m_last;
  logic xfer_end;
  assign s_last = !master_select && s_edge && (edge_cnt == LAST_EDGE);
  assign m_last = m_edge && (edge_cnt == LAST_EDGE);
  assign xfer_end = s_last || m_last;

  logic slave_busy;
  logic collide;
  logic accept;
  assign slave_busy = !master_select && (edge_cnt != EDGES_PER_BYTE);
  assign collide = wr_data && (busy || slave_busy ||
                   (!master_select && !pha && !ss_lvl));
  assign accept = wr_data && !collide;
  logic start;
  assign start = accept && master_select && enable;

  // flags clear after status read then data access
  logic flag_clear;
  assign flag_clear = status_seen && data_access;

  // Master sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      SSP_IDLE: if (start) next_state = SSP_LEAD;
      SSP_LEAD: if (half_tick) next_state = SSP_RUN;
      SSP_RUN: if (m_last) next_state = SSP_IDLE;
      default: next_state = SSP_IDLE;
    endcase
  end

  // Shift register
  logic [7:0] shift_data;
  logic shift_out;
  logic serial_in;
  assign serial_in = master_select ? miso_in : mosi_in;
  ssp_shifter u_shift (
    .clock(clock),
    .rst(rst),
    .load(accept),
    .load_data(reg_wdata),
    .lsb_first(lsb_first),
    .sample(do_sample),
    .shift(do_shift),
    .serial_in(serial_in),
    .serial_out(shift_out),
    .data(shift_data)
  );

  // Control and status bookkeeping
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      status_seen <= 1'b0;
      sclk_prev <= 1'b0;
      done_prev <= 1'b0;
      tail_shift <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata;
      end
      if (rd_flags) begin
        status_seen <= 1'b1;
      end else if (data_access) begin
        status_seen <= 1'b0;
      end
      sclk_prev <= sclk_lvl;
      done_prev <= done_flag;
      // Phase one ends on a sample edge; shift it in next cycle
      tail_shift <= xfer_end && pha;
    end
  end

  // Flags: a set in the clear cycle wins
  always_ff @(posedge clock) begin
    if (rst) begin
      done_flag <= 1'b0;
      write_collision_flag_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      done_flag <= xfer_end || (done_flag && !flag_clear);
      write_collision_flag_flag <= collide || (write_collision_flag_flag && !flag_clear);
      // slave overflow; master switch clears it
      ovf_flag <= (s_last && done_flag) ||
                  (ovf_flag && !flag_clear && !master_select);
    end
  end

  // Divider, edge counter and master clock
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= SSP_IDLE;
      div_cnt <= 5'h00;
      edge_cnt <= EDGES_PER_BYTE;
      sclk_int <= 1'b0;
    end else begin
      state <= next_state;
      if (start || half_tick) begin
        div_cnt <= half_of(rate);
      end else if (busy) begin
        div_cnt <= div_cnt - 5'h01;
      end
      if (any_edge) begin
        edge_cnt <= edge_cnt + 4'h1;
      end else if (!master_select && ss_lvl) begin
        edge_cnt <= EDGES_PER_BYTE;
      end
      if (m_edge) begin
        sclk_int <= !sclk_int;
      end else if (!busy) begin
        sclk_int <= 1'b0;
      end
    end
  end

  // clock pin driven only as master, idle at polarity
  assign sclk_oe = enable && master_select;
  assign sclk_out = sclk_int ^ pol;
  // mosi carries the current output bit
  assign mosi_oe = enable && master_select;
  assign mosi_out = shift_out;
  assign miso_oe = slave_sel;
  assign miso_out = shift_out;

  assign transfer_done_irq = done_flag && !done_prev;

  // Read data one cycle later
  logic [7:0] next_rdata;
  assign next_rdata =
    (reg_rd && reg_addr == CTRL_OFS) ? ctrl :
    rd_data ? shift_data :
    rd_flags ? {done_flag, write_collision_flag_flag, ovf_flag & !master_select, 5'h00} : 8'h00;
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  chk_done_after_last: assert property (
    @(posedge clock) disable iff (rst) xfer_end |=> done_flag)
    else $error("done flag not set");
  chk_collide_sets_write_collision_flag: assert property (
    @(posedge clock) disable iff (rst) (wr_data && busy) |=> write_collision_flag_flag)
    else $error("collision missed");
  chk_slave_no_drive: assert property (
    @(posedge clock) disable iff (rst)
    (!master_select && ss_n) [*5] |-> !miso_oe)
    else $error("miso driven");
  chk_idle_clock_level: assert property (
    @(posedge clock) disable iff (rst)
    (master_select && !busy) |-> (sclk_out == pol))
    else $error("clock not idle");
  chk_irq_on_rise: assert property (
    @(posedge clock) disable iff (rst)
    $rose(done_flag) |-> transfer_done_irq)
    else $error("irq missing");
  chk_master_len: assert property (
    @(posedge clock) disable iff (rst)
    (start && rate == 2'b00) |-> ##34 busy ##1 !busy)
    else $error("master transfer length");
  chk_slave_pha0: assert property (
    @(posedge clock) disable iff (rst)
    (wr_data && !master_select && !pha && !ss_lvl) |=> write_collision_flag_flag)
    else $error("slave collision missed");
  chk_ovf_slave: assert property (
    @(posedge clock) disable iff (rst)
    (s_last && done_flag) |=> ovf_flag)
    else $error("overflow missed");
  // Main scenarios
  cov_master: cover property (@(posedge clock) start ##[1:300] m_last);
  cov_slave: cover property (@(posedge clock) s_last);
  cov_write_collision_flag: cover property (@(posedge clock) collide);
endmodule

// ---- sim/ssp_peer.sv ----
`timescale 1ns/1ps
// Slave peripheral model, most significant bit first
module ssp_peer (
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic sel_n,
  output logic miso,
  // Format and data
  input wire logic clock_polarity_select,
  input wire logic clock_phase_select,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  initial miso = 1'b0;
  assign rx = sh;
  // Load on select; a released line shows the inverse level
  always @(sel_n) begin
    if (!sel_n) begin
      sh = tx;
      miso = tx[7];
    end else begin
      miso = ~miso;
    end
  end
  always @(sclk) begin
    if (!sel_n && ((sclk != clock_polarity_select) != clock_phase_select)) begin
      sh = {sh[6:0], mosi};
    end else if (!sel_n) begin
      miso = sh[7];
    end
  end
endmodule

// ---- sim/test_ssp_top.sv ----
`timescale 1ns/1ps
module test_ssp_top
  import ssp_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sck_t = 1'b0;
  logic mosi_t = 1'b0;
  logic ss_n = 1'b1;
  logic psel_n = 1'b1;
  logic cur_pol = 1'b0;
  logic cur_pha = 1'b0;
  logic lv = 1'b0;
  logic first;
  logic [7:0] ptx = 8'h00;
  logic [7:0] prx, reg_rdata;
  logic sclk_out, sclk_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, pmiso, transfer_done_irq;
  // pins reach the port directly, latches taken as set
  wire logic sclk_w = sclk_oe ? sclk_out : sck_t;
  wire logic mosi_w = mosi_oe ? mosi_out : mosi_t;
  wire logic miso_w = miso_oe ? miso_out : pmiso;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int act, pul, irqs;
  always #2 clock = ~clock;
  ssp_top u_ssp_top (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sclk_in(sclk_w), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n(ss_n), .transfer_done_irq(transfer_done_irq));
  ssp_peer u_ssp_peer (.sclk(sclk_w), .mosi(mosi_w), .sel_n(psel_n),
    .miso(pmiso), .clock_polarity_select(cur_pol), .clock_phase_select(cur_pha), .tx(ptx), .rx(prx));
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // Clock activity, pulse, first bit and interrupt counts
  always @(posedge clock) begin
    cycles++;
    if ((sclk_out ^ cur_pol) && !lv) begin
      if (pul == 0) first = mosi_out;
      pul++;
    end
    act = act + (sclk_out ^ cur_pol);
    lv = sclk_out ^ cur_pol;
    irqs = irqs + transfer_done_irq;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rv(input logic [7:0] a, input string n, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(n, d, e);
  endtask
  task automatic oe(input logic [2:0] e);
    #1 check("oe", {sclk_oe, mosi_oe, miso_oe}, e);
  endtask
  // Master transfer against the peer model
  task automatic mx(input logic [1:0] m, input logic bit_order_select,
      input logic [7:0] tx, p, input logic col);
    int dv;
    logic [7:0] d;
    logic [7:0] c;
    dv = (m == 2'd3) ? 64 : (4 << m);
    c = {2'b11, bit_order_select, 1'b1, m[1], m[0], m};
    cur_pol = m[1];
    cur_pha = m[0];
    ptx = p;
    wr(CTRL_OFS, c);
    rv(CTRL_OFS, "ctrl", c);
    psel_n <= 1'b0;
    act = 0;
    pul = 0;
    irqs = 0;
    wr(DATA_OFS, tx);
    oe(3'b110);
    if (col) begin
      repeat (40) @(posedge clock);
      wr(DATA_OFS, ~tx);
    end
    d = 8'h00;
    for (int i = 0; i < 400 && !d[7]; i++) rd(FLAGS_OFS, d);
    check("flags", d, {1'b1, col, 6'h00});
    check("pulses", pul[15:0], 16'h0008);
    check("active", act[15:0], 16'(4 * dv));
    check("idle", sclk_out, cur_pol);
    check("irq", irqs[15:0], 16'h0001);
    check("first", first, bit_order_select ? tx[0] : tx[7]);
    check("peer", prx, bit_order_select ? {<<{tx}} : tx);
    rv(DATA_OFS, "rx", bit_order_select ? {<<{p}} : p);
    rv(FLAGS_OFS, "clear", 8'h00);
    psel_n <= 1'b1;
  endtask
  // Bench acts as master on the slave pins, 32 cycles a bit
  task automatic sx(input logic pha, input logic [7:0] tx, e,
      input logic chk);
    logic [7:0] r;
    @(posedge clock);
    for (int i = 7; i >= 0; i--) begin
      sck_t <= pha;
      mosi_t <= tx[i];
      repeat (16) @(posedge clock);
      r[i] = miso_w;
      sck_t <= !pha;
      repeat (16) @(posedge clock);
    end
    sck_t <= 1'b0;
    repeat (12) @(posedge clock);
    if (chk) check("miso", r, e);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rv(CTRL_OFS, "ctrl0", CTRL_RST);
    rv(DATA_OFS, "data0", DATA_RST);
    rv(FLAGS_OFS, "flags0", 8'h00);
    rv(8'h00, "unmapped", 8'h00);
    for (int m = 0; m < 4; m++) begin
      mx(m[1:0], m == 2, 8'(8'h96 + m), 8'(8'h3b ^ m), m == 3);
    end
    wr(CTRL_OFS, 8'hc0);
    oe(3'b000);
    wr(DATA_OFS, 8'h3c);
    @(posedge clock) ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    oe(3'b001);
    sx(1'b0, 8'ha5, 8'h3c, 1'b1);
    wr(DATA_OFS, 8'h11);
    rv(FLAGS_OFS, "write_collision_flag", 8'hc0);
    rv(DATA_OFS, "srx", 8'ha5);
    sx(1'b0, 8'h5e, 8'ha5, 1'b1);
    sx(1'b0, 8'h77, 8'h5e, 1'b1);
    rv(FLAGS_OFS, "ovf", 8'ha0);
    rv(DATA_OFS, "srx2", 8'h77);
    @(posedge clock) ss_n <= 1'b1;
    repeat (8) @(posedge clock);
    oe(3'b000);
    sx(1'b0, 8'hff, 8'h00, 1'b0);
    rv(DATA_OFS, "hold", 8'h77);
    rv(FLAGS_OFS, "idle", 8'h00);
    wr(CTRL_OFS, 8'hc4);
    @(posedge clock) ss_n <= 1'b0;
    repeat (8) @(posedge clock);
    wr(DATA_OFS, 8'h5a);
    sx(1'b1, 8'hc3, 8'h5a, 1'b1);
    rv(FLAGS_OFS, "pha1", 8'h80);
    rv(DATA_OFS, "srx3", 8'hc3);
    stop_test();
  end
endmodule
